/* core/fbod_defines.vh */
// constants for the flash bus operation decode block
//
// Contract
// - four 32 KB boot sectors, bottom and top
// - sixteen 1 MB banks of 128 KB sectors
// - 128 KB sectors on 010000h-aligned ranges
// - command register is latches, not array-mapped
// - latched command feeds the state machine
// - bad sequence needs reset command to recover
// - power-up and hardware reset give async read
// - async read returns one location per access
// - strobe rise latches address, low follows inputs
// - data driven access time after enable falls
// - clock edge with strobe low starts burst
// - each clock with strobe high and output enable low advances burst
// - select high ends burst, outputs float
// - hardware reset ends burst, outputs float
// - new clocked address capture restarts burst
`ifndef FBOD_DEFINES_VH
`define FBOD_DEFINES_VH

`define FBOD_ADDR_W 23
`define FBOD_DATA_W 16
`define FBOD_MEM_AW 8
`define FBOD_MEM_DEPTH 256

// timing
`define FBOD_CLK_NS 100
`define FBOD_OE_ACC_NS 20
`define FBOD_OE_ACC_RAW \
  ((`FBOD_OE_ACC_NS + `FBOD_CLK_NS - 1) / `FBOD_CLK_NS)
`define FBOD_OE_ACC_CYC \
  ((`FBOD_OE_ACC_RAW < 1) ? 1 : `FBOD_OE_ACC_RAW)

// address map fields
`define FBOD_BANK_HI 22
`define FBOD_BANK_LO 19
`define FBOD_PAGE_HI 22
`define FBOD_PAGE_LO 16
`define FBOD_BOOT_HI 15
`define FBOD_BOOT_LO 14
`define FBOD_PAGE_BOT 7'h00
`define FBOD_PAGE_TOP 7'h7f
`define FBOD_MAIN_OFS 8'h03
`define FBOD_TOP_BOOT_BASE 8'h82

// command codes
`define FBOD_CMD_RESET 8'hf0
`define FBOD_CMD_PROG 8'ha0
`define FBOD_CMD_SYNC 8'hc0
`define FBOD_CMD_ASYNC 8'hcf

// reset values
`define FBOD_STATUS_WORD 16'hffff
`define FBOD_SYNC_RST 1'b0

`endif

/* core/fbod_mem.v */
// small word array behind the bus front end
`timescale 1ns/1ns
`include "fbod_defines.vh"
module fbod_mem (
  // clock
  input wire i_sys_clk,
  // write port
  input wire i_wr_en,
  input wire [`FBOD_MEM_AW-1:0] i_wr_addr,
  input wire [`FBOD_DATA_W-1:0] i_wr_data,
  // read port
  input wire [`FBOD_MEM_AW-1:0] i_rd_addr,
  output reg [`FBOD_DATA_W-1:0] o_rd_data
);

reg [`FBOD_DATA_W-1:0] mem_r [0:`FBOD_MEM_DEPTH-1];

// no reset: array contents are data, not control
always @(posedge i_sys_clk) begin
  if (i_wr_en) begin
    mem_r[i_wr_addr] <= i_wr_data;
  end
  o_rd_data <= mem_r[i_rd_addr];
end

endmodule // fbod_mem

/* core/fbod_top.v */
// flash bus front end: pin decode, address latch, burst, command fsm
`timescale 1ns/1ns
`include "fbod_defines.vh"
module fbod_top (
  // system
  input wire i_sys_clk,
  input wire i_reset_n,
  // flash control pins
  input wire i_chip_sel_n,
  input wire i_out_en_n,
  input wire i_wr_en_n,
  input wire i_address_valid_n,
  input wire i_burst_clk,
  input wire i_hw_reset_n,
  // address and data pins
  input wire [`FBOD_ADDR_W-1:0] i_addr,
  input wire [`FBOD_DATA_W-1:0] i_data_lines,
  output reg [`FBOD_DATA_W-1:0] o_data_lines,
  output reg o_data_lines_oe,
  // ready pin
  output reg o_rdy,
  output reg o_rdy_oe,
  // decode status
  output reg [3:0] o_bank,
  output reg [7:0] o_sector,
  output reg o_boot_sector,
  output reg o_sync_mode,
  output reg [1:0] o_cmd_state,
  // latched command
  output reg o_cmd_valid,
  output reg [`FBOD_ADDR_W-1:0] o_cmd_addr,
  output reg [`FBOD_DATA_W-1:0] o_cmd_data,
  output reg [7:0] o_cmd_sector
);

////////////////////////////////////////////////////////////////////////
// address map functions
function [3:0] fbod_bank;
  input [`FBOD_ADDR_W-1:0] a;
  begin
    fbod_bank = a[`FBOD_BANK_HI:`FBOD_BANK_LO];
  end
endfunction
function fbod_is_boot;
  input [`FBOD_ADDR_W-1:0] a;
  reg [6:0] pg;
  begin
    pg = a[`FBOD_PAGE_HI:`FBOD_PAGE_LO];
    fbod_is_boot = (pg == `FBOD_PAGE_BOT) ||
                   (pg == `FBOD_PAGE_TOP);
  end
endfunction
function [7:0] fbod_sector;
  input [`FBOD_ADDR_W-1:0] a;
  reg [6:0] pg;
  reg [1:0] bt;
  begin
    pg = a[`FBOD_PAGE_HI:`FBOD_PAGE_LO];
    bt = a[`FBOD_BOOT_HI:`FBOD_BOOT_LO];
    if (pg == `FBOD_PAGE_BOT) begin
      fbod_sector = {6'h00, bt};
    end else if (pg == `FBOD_PAGE_TOP) begin
      fbod_sector = `FBOD_TOP_BOOT_BASE + {6'h00, bt};
    end else begin
      // one sector per 010000h page, seven per end bank
      fbod_sector = {1'b0, pg} + `FBOD_MAIN_OFS;
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////
// pin synchronisers
localparam [5:0] CTL_RST = 6'h3d; // burst clock idles low: no false edge
reg [5:0] ctl_m_r;
reg [5:0] ctl_s_r;
reg [`FBOD_ADDR_W-1:0] adr_m_r;
reg [`FBOD_ADDR_W-1:0] adr_s_r;
reg [`FBOD_DATA_W-1:0] din_m_r;
reg [`FBOD_DATA_W-1:0] din_s_r;
always @(posedge i_sys_clk or negedge i_reset_n) begin
  if (!i_reset_n) begin
    ctl_m_r <= CTL_RST;
    ctl_s_r <= CTL_RST;
    adr_m_r <= {`FBOD_ADDR_W{1'b0}};
    adr_s_r <= {`FBOD_ADDR_W{1'b0}};
    din_m_r <= {`FBOD_DATA_W{1'b0}};
    din_s_r <= {`FBOD_DATA_W{1'b0}};
  end else begin
    ctl_m_r <= {i_chip_sel_n, i_out_en_n, i_wr_en_n,
                i_address_valid_n, i_burst_clk, i_hw_reset_n};
    ctl_s_r <= ctl_m_r;
    adr_m_r <= i_addr;
    adr_s_r <= adr_m_r;
    din_m_r <= i_data_lines;
    din_s_r <= din_m_r;
  end
end
wire ce_n = ctl_s_r[5];
wire oe_n = ctl_s_r[4];
wire we_n = ctl_s_r[3];
wire avd_n = ctl_s_r[2];
wire bclk = ctl_s_r[1];
wire hw_rst = ~ctl_s_r[0];

////////////////////////////////////////////////////////////////////////
// edge detection on synchronised pins
reg oe_d_r;
reg we_d_r;
reg bclk_d_r;
always @(posedge i_sys_clk or negedge i_reset_n) begin
  if (!i_reset_n) begin
    oe_d_r <= 1'b1;
    we_d_r <= 1'b1;
    bclk_d_r <= 1'b0;
  end else begin
    oe_d_r <= oe_n;
    we_d_r <= we_n;
    bclk_d_r <= bclk;
  end
end
wire oe_fall = oe_d_r & ~oe_n;
wire we_rise = ~we_d_r & we_n;
wire bclk_rise = ~bclk_d_r & bclk;
wire selected = ~ce_n & ~hw_rst;

////////////////////////////////////////////////////////////////////////
// asynchronous address latch
reg [`FBOD_ADDR_W-1:0] async_addr_r;
// while the strobe is low the latch is transparent; the last value
// seen low is what the rising strobe leaves behind
always @(posedge i_sys_clk or negedge i_reset_n) begin
  if (!i_reset_n) begin
    async_addr_r <= {`FBOD_ADDR_W{1'b0}};
  end else if (!avd_n) begin
    async_addr_r <= adr_s_r;
  end
end

////////////////////////////////////////////////////////////////////////
// burst engine
reg sync_mode_r;
reg burst_act_r;
reg burst_vld_r;
reg [`FBOD_ADDR_W-1:0] burst_addr_r;
wire burst_edge = bclk_rise & selected & we_n & sync_mode_r;
always @(posedge i_sys_clk or negedge i_reset_n) begin
  if (!i_reset_n) begin
    burst_act_r <= 1'b0;
    burst_vld_r <= 1'b0;
    burst_addr_r <= {`FBOD_ADDR_W{1'b0}};
  end else if (hw_rst) begin
    burst_act_r <= 1'b0;
    burst_vld_r <= 1'b0;
  end else if (ce_n) begin
    burst_act_r <= 1'b0;
    burst_vld_r <= 1'b0;
  end else if (burst_edge && !avd_n) begin
    // a fresh capture drops whatever burst was running
    burst_addr_r <= adr_s_r;
    burst_act_r <= 1'b1;
    burst_vld_r <= 1'b0;
  end else if (burst_edge && burst_act_r && !oe_n) begin
    burst_addr_r <= burst_addr_r + 1'b1;
    burst_vld_r <= 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////
// output enable access timer
localparam integer OE_ACC_INT = `FBOD_OE_ACC_CYC;
localparam [3:0] OE_ACC_CYC = OE_ACC_INT[3:0];
reg [3:0] acc_cnt_r;
reg acc_done_r;
always @(posedge i_sys_clk or negedge i_reset_n) begin
  if (!i_reset_n) begin
    acc_cnt_r <= 4'h0;
    acc_done_r <= 1'b0;
  end else if (oe_n || !selected) begin
    acc_cnt_r <= 4'h0;
    acc_done_r <= 1'b0;
  end else if (oe_fall) begin
    acc_cnt_r <= OE_ACC_CYC - 4'h1;
    acc_done_r <= (OE_ACC_CYC == 4'h1);
  end else if (acc_cnt_r != 4'h0) begin
    acc_cnt_r <= acc_cnt_r - 4'h1;
    acc_done_r <= (acc_cnt_r == 4'h1);
  end
end

////////////////////////////////////////////////////////////////////////
// command register and state machine
localparam [1:0] ST_READ = 2'h0;
localparam [1:0] ST_PROG = 2'h1;
localparam [1:0] ST_UNKNOWN = 2'h2;
reg [1:0] st_r;
reg cmd_stb_r;
reg [`FBOD_ADDR_W-1:0] cmd_addr_r;
reg [`FBOD_DATA_W-1:0] cmd_data_r;
reg mem_we_r;

// command latch sits beside the array, never at an array address
always @(posedge i_sys_clk or negedge i_reset_n) begin
  if (!i_reset_n) begin
    cmd_stb_r <= 1'b0;
    cmd_addr_r <= {`FBOD_ADDR_W{1'b0}};
    cmd_data_r <= {`FBOD_DATA_W{1'b0}};
  end else begin
    cmd_stb_r <= we_rise & selected;
    if (we_rise && selected) begin
      cmd_addr_r <= adr_s_r;
      cmd_data_r <= din_s_r;
    end
  end
end
wire [7:0] cmd_code = cmd_data_r[7:0];
always @(posedge i_sys_clk or negedge i_reset_n) begin
  if (!i_reset_n) begin
    st_r <= ST_READ;
    sync_mode_r <= `FBOD_SYNC_RST;
    mem_we_r <= 1'b0;
  end else if (hw_rst) begin
    st_r <= ST_READ;
    sync_mode_r <= `FBOD_SYNC_RST;
    mem_we_r <= 1'b0;
  end else begin
    mem_we_r <= 1'b0;
    if (cmd_stb_r) begin
      case (st_r)
        ST_READ: begin
          if (cmd_code == `FBOD_CMD_PROG) begin
            st_r <= ST_PROG;
          end else if (cmd_code == `FBOD_CMD_SYNC) begin
            sync_mode_r <= 1'b1;
          end else if (cmd_code == `FBOD_CMD_ASYNC) begin
            sync_mode_r <= 1'b0;
          end else if (cmd_code != `FBOD_CMD_RESET) begin
            st_r <= ST_UNKNOWN;
          end
        end
        ST_PROG: begin
          mem_we_r <= 1'b1;
          st_r <= ST_READ;
        end
        ST_UNKNOWN: begin
          // only the reset command or a hardware reset gets out of here
          if (cmd_code == `FBOD_CMD_RESET) begin
            st_r <= ST_READ;
          end
        end
        default: begin
          st_r <= ST_READ;
        end
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////
// array
wire [`FBOD_ADDR_W-1:0] rd_addr = burst_act_r ? burst_addr_r : async_addr_r;
wire [`FBOD_DATA_W-1:0] rd_data;
// one location per access, chosen by the current address
fbod_mem u_mem (
  .i_sys_clk (i_sys_clk),
  .i_wr_en (mem_we_r),
  .i_wr_addr (cmd_addr_r[`FBOD_MEM_AW-1:0]),
  .i_wr_data (cmd_data_r),
  .i_rd_addr (rd_addr[`FBOD_MEM_AW-1:0]),
  .o_rd_data (rd_data)
);

////////////////////////////////////////////////////////////////////////
// pin drive decode
reg [`FBOD_DATA_W-1:0] dq_nxt;
reg dq_oe_nxt;
reg rdy_nxt;
reg rdy_oe_nxt;
always @* begin
  dq_nxt = rd_data;
  dq_oe_nxt = 1'b0;
  rdy_nxt = 1'b0;
  rdy_oe_nxt = 1'b0;
  if (hw_rst || ce_n) begin
    // float regardless of every other pin
    dq_oe_nxt = 1'b0;
    rdy_oe_nxt = 1'b0;
  end else if (burst_act_r) begin
    rdy_oe_nxt = 1'b1;
    rdy_nxt = burst_vld_r;
    dq_oe_nxt = ~oe_n & we_n;
  end else begin
    rdy_oe_nxt = 1'b1;
    rdy_nxt = 1'b1;
    dq_oe_nxt = ~oe_n & we_n & avd_n & acc_done_r;
    if (st_r != ST_READ) begin
      dq_nxt = `FBOD_STATUS_WORD;
    end
  end
end
always @(posedge i_sys_clk or negedge i_reset_n) begin
  if (!i_reset_n) begin
    o_data_lines <= {`FBOD_DATA_W{1'b0}};
    o_data_lines_oe <= 1'b0;
    o_rdy <= 1'b0;
    o_rdy_oe <= 1'b0;
  end else begin
    o_data_lines <= dq_nxt;
    o_data_lines_oe <= dq_oe_nxt;
    o_rdy <= rdy_nxt;
    o_rdy_oe <= rdy_oe_nxt;
  end
end

////////////////////////////////////////////////////////////////////////
// status outputs
always @(posedge i_sys_clk or negedge i_reset_n) begin
  if (!i_reset_n) begin
    o_bank <= 4'h0;
    o_sector <= 8'h00;
    o_boot_sector <= 1'b0;
    o_sync_mode <= 1'b0;
    o_cmd_state <= ST_READ;
    o_cmd_valid <= 1'b0;
    o_cmd_addr <= {`FBOD_ADDR_W{1'b0}};
    o_cmd_data <= {`FBOD_DATA_W{1'b0}};
    o_cmd_sector <= 8'h00;
  end else begin
    o_bank <= fbod_bank(rd_addr);
    o_sector <= fbod_sector(rd_addr);
    o_boot_sector <= fbod_is_boot(rd_addr);
    o_sync_mode <= sync_mode_r;
    o_cmd_state <= st_r;
    o_cmd_valid <= cmd_stb_r;
    o_cmd_addr <= cmd_addr_r;
    o_cmd_data <= cmd_data_r;
    o_cmd_sector <= fbod_sector(cmd_addr_r);
  end
end
endmodule // fbod_top

/* testbench/fbod_host.sv */
// host processor model driving the flash bus pins
`timescale 1ns/1ns
module fbod_host (
  // clock
  input wire i_sys_clk,
  // device answer
  input wire [15:0] i_dq,
  input wire i_dq_oe,
  // bus pins
  output reg o_ce_n = 1'b1,
  output reg o_oe_n = 1'b1,
  output reg o_we_n = 1'b1,
  output reg o_avd_n = 1'b1,
  output reg o_bclk = 1'b0,
  output reg [22:0] o_addr = 23'h000000,
  output reg [15:0] o_dq = 16'h0000
);
  task automatic cyc(input integer n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic idle;
    @(negedge i_sys_clk);
    o_oe_n = 1'b1;
    o_ce_n = 1'b1;
    cyc(4);
  endtask
  // released lines are inverted so stale values never look valid
  task automatic wr(input [22:0] a, input [15:0] d);
    @(negedge i_sys_clk);
    o_ce_n = 1'b0;
    o_addr = a;
    o_dq = d;
    o_we_n = 1'b0;
    cyc(4);
    o_we_n = 1'b1;
    cyc(6);
    o_ce_n = 1'b1;
    o_dq = ~d;
    o_addr = ~a;
    cyc(4);
  endtask
  task automatic rd(input [22:0] a, output [15:0] d);
    integer i;
    @(negedge i_sys_clk);
    o_ce_n = 1'b0;
    o_avd_n = 1'b0;
    o_addr = a;
    cyc(3);
    o_avd_n = 1'b1;
    cyc(2);
    o_addr = ~a;
    o_oe_n = 1'b0;
    for (i = 0; i < 12 && i_dq_oe !== 1'b1; i = i + 1) cyc(1);
    cyc(1);
    d = i_dq_oe ? i_dq : 16'hxxxx;
    cyc(4);
    idle;
  endtask
  // strobe held low: the address latch tracks the pins
  task automatic follow(input [22:0] a);
    @(negedge i_sys_clk);
    o_ce_n = 1'b0;
    o_avd_n = 1'b0;
    o_addr = a;
    cyc(5);
  endtask
  // burst clock stands low outside frames
  task automatic clk8;
    o_bclk = 1'b1;
    cyc(4);
    o_bclk = 1'b0;
    cyc(4);
  endtask
  task automatic bst(input [22:0] a);
    @(negedge i_sys_clk);
    o_ce_n = 1'b0;
    o_avd_n = 1'b0;
    o_addr = a;
    cyc(3);
    clk8;
    o_avd_n = 1'b1;
    o_addr = ~a;
  endtask
  task automatic badv;
    o_oe_n = 1'b0;
    cyc(3);
    clk8;
  endtask
endmodule // fbod_host

/* testbench/fbod_top_properties.sv */
// assertion checker for the flash bus front end
`timescale 1ns/1ns
module fbod_props (
  // system
  input wire i_sys_clk,
  input wire i_reset_n,
  // pins
  input wire i_chip_sel_n,
  input wire i_out_en_n,
  input wire i_wr_en_n,
  input wire i_address_valid_n,
  input wire i_hw_reset_n,
  // outputs
  input wire o_data_lines_oe,
  input wire o_rdy_oe,
  input wire [3:0] o_bank,
  input wire [7:0] o_sector,
  input wire o_boot_sector,
  input wire o_sync_mode,
  input wire [1:0] o_cmd_state,
  input wire o_cmd_valid
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  function automatic [3:0] bk(input [7:0] s);
    reg [7:0] p;
    p = s - 8'h03;
    if (s < 8'h04) bk = 4'h0;
    else if (s > 8'h81) bk = 4'hf;
    else bk = p[6:3];
  endfunction
  sequence s_rd;
    !i_chip_sel_n && !i_out_en_n && i_wr_en_n && i_address_valid_n
      && i_hw_reset_n && !o_sync_mode;
  endsequence
  sequence s_wr;
    !i_wr_en_n && !i_chip_sel_n && i_hw_reset_n ##1
      i_wr_en_n && !i_chip_sel_n;
  endsequence
  property p_map;
    o_data_lines_oe && $stable(o_sector) |-> o_bank == bk(o_sector);
  endproperty
  a_map: assert property (p_map)
    else $error("bank and sector disagree");
  property p_boot;
    o_data_lines_oe && $stable(o_sector) |->
      o_boot_sector == (o_sector < 8'h04 || o_sector > 8'h81);
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot flag wrong");
  property p_hwf;
    !i_hw_reset_n [*5] |-> !o_data_lines_oe && !o_rdy_oe;
  endproperty
  a_hwf: assert property (p_hwf)
    else $error("driving during hardware reset");
  property p_self;
    i_chip_sel_n [*5] |-> !o_data_lines_oe && !o_rdy_oe;
  endproperty
  a_self: assert property (p_self)
    else $error("driving while deselected");
  property p_hwm;
    !i_hw_reset_n [*5] |-> !o_sync_mode && o_cmd_state == 2'h0;
  endproperty
  a_hwm: assert property (p_hwm)
    else $error("mode not restored by hardware reset");
  property p_rd;
    s_rd [*8] |-> o_data_lines_oe;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read data not driven");
  property p_pulse;
    o_cmd_valid |=> !o_cmd_valid;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("command strobe too long");
  property p_take;
    s_wr |-> ##[1:5] o_cmd_valid;
  endproperty
  a_take: assert property (p_take)
    else $error("write not latched");
endmodule // fbod_props

bind fbod_top fbod_props u_props (.i_sys_clk(i_sys_clk),
  .i_reset_n(i_reset_n), .i_chip_sel_n(i_chip_sel_n),
  .i_out_en_n(i_out_en_n), .i_wr_en_n(i_wr_en_n),
  .i_address_valid_n(i_address_valid_n), .i_hw_reset_n(i_hw_reset_n),
  .o_data_lines_oe(o_data_lines_oe), .o_rdy_oe(o_rdy_oe),
  .o_bank(o_bank), .o_sector(o_sector), .o_boot_sector(o_boot_sector),
  .o_sync_mode(o_sync_mode), .o_cmd_state(o_cmd_state),
  .o_cmd_valid(o_cmd_valid));

/* testbench/test_flash_bus_operation_decode.sv */
// self-checking bench for the flash bus front end
`timescale 1ns/1ns
module test_flash_bus_operation_decode;
  reg i_sys_clk = 1'b0;
  reg i_reset_n = 1'b0;
  reg i_hw_reset_n = 1'b1;
  wire ce_n, oe_n, we_n, avd_n, bclk, dq_oe, rdy, rdy_oe, sync, boot;
  wire cvld;
  wire [22:0] addr, caddr;
  wire [15:0] dq_in, dq_out, cdata;
  wire [3:0] bank;
  wire [7:0] sec, csec;
  wire [1:0] st;
  integer n_fail = 0;
  integer cmp_count = 0;
  integer n_cmd = 0;
  // one count per latched command strobe
  always @(posedge i_sys_clk) begin
    if (cvld === 1'b1) n_cmd <= n_cmd + 1;
  end
  // {word address, sector, boot} per entry
  localparam [191:0] MAP = {32'h00000a01, 32'h01800a07, 32'h02000a08,
    32'h74000a7a, 32'hf0000af6, 32'hff800b0b};
  initial forever #50 i_sys_clk = ~i_sys_clk;
  fbod_top u_dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_chip_sel_n(ce_n), .i_out_en_n(oe_n), .i_wr_en_n(we_n),
    .i_address_valid_n(avd_n), .i_burst_clk(bclk),
    .i_hw_reset_n(i_hw_reset_n), .i_addr(addr), .i_data_lines(dq_in),
    .o_data_lines(dq_out), .o_data_lines_oe(dq_oe), .o_rdy(rdy),
    .o_rdy_oe(rdy_oe), .o_bank(bank), .o_sector(sec),
    .o_boot_sector(boot), .o_sync_mode(sync), .o_cmd_state(st),
    .o_cmd_valid(cvld), .o_cmd_addr(caddr), .o_cmd_data(cdata),
    .o_cmd_sector(csec));
  fbod_host u_host (.i_sys_clk(i_sys_clk), .i_dq(dq_out),
    .i_dq_oe(dq_oe), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
    .o_avd_n(avd_n), .o_bclk(bclk), .o_addr(addr), .o_dq(dq_in));
  task automatic chk(input [31:0] got, input [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic t_prog;
    integer n0;
    n0 = n_cmd;
    u_host.wr(23'h000555, 16'h00a0);
    chk(st, 2'h1);
    u_host.wr(23'h010005, 16'h1234);
    chk(st, 2'h0);
    chk(caddr, 23'h010005);
    chk(cdata, 16'h1234);
    chk(csec, 8'h04);
    u_host.wr(23'h000555, 16'h00a0);
    u_host.wr(23'h000011, 16'hbeef);
    chk(n_cmd - n0, 4);
    $display("program test done");
  endtask
  task automatic t_map;
    reg [31:0] e;
    reg [15:0] d;
    integer i;
    for (i = 0; i < 6; i = i + 1) begin
      e = MAP[i*32 +: 32];
      u_host.rd(e[31:9], d);
      chk(d, 16'h1234);
      chk(bank, e[31:28]);
      chk(sec, e[8:1]);
      chk(boot, e[0]);
    end
    u_host.follow(23'h7f4000);
    chk(sec, 8'h83);
    chk(boot, 1'b1);
    u_host.follow(23'h080005);
    chk(sec, 8'h0b);
    chk(bank, 4'h1);
    u_host.rd(23'h080005, d);
    chk(d, 16'h1234);
    $display("map test done");
  endtask
  task automatic t_bad;
    reg [15:0] d;
    u_host.wr(23'h000555, 16'h0055);
    chk(st, 2'h2);
    u_host.rd(23'h010005, d);
    chk(d, 16'hffff);
    u_host.wr(23'h000555, 16'h00f0);
    chk(st, 2'h0);
    u_host.rd(23'h010005, d);
    chk(d, 16'h1234);
    $display("recovery test done");
  endtask
  task automatic t_burst;
    u_host.wr(23'h000555, 16'h00c0);
    chk(sync, 1'b1);
    u_host.bst(23'h000004);
    chk(rdy, 1'b0);
    u_host.badv;
    chk({dq_oe, rdy}, 2'h3);
    chk(dq_out, 16'h1234);
    u_host.bst(23'h000010);
    chk(rdy, 1'b0);
    u_host.badv;
    chk(dq_out, 16'hbeef);
    u_host.idle;
    chk({dq_oe, rdy_oe}, 2'h0);
    u_host.wr(23'h000555, 16'h00cf);
    chk(sync, 1'b0);
    $display("burst test done");
  endtask
  task automatic t_hw;
    reg [15:0] d;
    u_host.wr(23'h000555, 16'h00c0);
    u_host.bst(23'h000004);
    u_host.badv;
    i_hw_reset_n = 1'b0;
    u_host.cyc(6);
    chk({dq_oe, rdy_oe}, 2'h0);
    chk({sync, st}, 3'h0);
    i_hw_reset_n = 1'b1;
    u_host.idle;
    u_host.rd(23'h010005, d);
    chk(d, 16'h1234);
    $display("hardware reset test done");
  endtask
  initial begin
    repeat (40000) @(posedge i_sys_clk);
    n_fail = n_fail + 1;
    report_and_stop;
  end
  initial begin
    repeat (20) @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    u_host.cyc(2);
    chk({sync, st, dq_oe, rdy_oe}, 5'h00);
    t_prog;
    t_map;
    t_bad;
    t_burst;
    t_hw;
    report_and_stop;
  end
endmodule // test_flash_bus_operation_decode
